//--- design/spcc_pkg.sv
package spcc_pkg;

  // Pin function codes stored in the nonvolatile image
  localparam logic [3:0] FN_TX_LED    = 4'h0;
  localparam logic [3:0] FN_RX_LED    = 4'h1;
  localparam logic [3:0] FN_ANY_LED   = 4'h2;
  localparam logic [3:0] FN_PWR_EN    = 4'h3;
  localparam logic [3:0] FN_SUSPEND   = 4'h4;

  localparam int NUM_PINS  = 5;
  localparam int NUM_UART  = 8;
  localparam int NV_WORDS  = 8;
  localparam int NV_AW     = 3;

  // Word addresses inside the nonvolatile store
  localparam logic [2:0] NV_ADDR_PIN01   = 3'h0;
  localparam logic [2:0] NV_ADDR_PIN234  = 3'h1;
  localparam logic [2:0] NV_ADDR_OPTIONS = 3'h2;
  localparam logic [2:0] NV_ADDR_USB     = 3'h3;
  localparam logic [2:0] NV_ADDR_LAST    = 3'h3;

  // Option word field positions
  localparam int OPT_INV_LSB     = 0;
  localparam int OPT_PULLDN_BIT  = 8;
  localparam int OPT_WAKE_BIT    = 9;

  // UART line order within the inversion mask
  localparam int UL_TXD = 0;
  localparam int UL_RXD = 1;
  localparam int UL_RTS = 2;
  localparam int UL_CTS = 3;
  localparam int UL_DTR = 4;
  localparam int UL_DSR = 5;
  localparam int UL_DCD = 6;
  localparam int UL_RI  = 7;

  // Default contents of the store
  localparam logic [15:0] NV_DEF_PIN01   = 16'h0001;
  localparam logic [15:0] NV_DEF_PIN234  = 16'h0433;
  localparam logic [15:0] NV_DEF_OPTIONS = 16'h0200;
  localparam logic [15:0] NV_DEF_USB     = 16'h0200;
  localparam logic [15:0] USB_VER_20     = 16'h0200;
  localparam logic [15:0] NV_DEF_BLANK   = 16'h0000;

  // One-shot stretch time and its cycle count at 10 MHz
  localparam int CLK_PERIOD_NS    = 100;
  localparam int ONESHOT_US       = 50;
  localparam int ONESHOT_CYCLES   = (ONESHOT_US * 1000) / CLK_PERIOD_NS;
  localparam int OS_W             = 10;
  localparam logic [OS_W-1:0] OS_LOAD = OS_W'(ONESHOT_CYCLES);

  // Resume signalling length
  localparam int RESUME_US        = 10;
  localparam int RESUME_CYCLES    = (RESUME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [OS_W-1:0] RS_LOAD = OS_W'(RESUME_CYCLES);

  typedef struct packed {
    logic [NUM_PINS-1:0][3:0] pin_fn;
    logic [NUM_UART-1:0]      invert;
    logic                     pulldown_en;
    logic                     wake_en;
    logic [15:0]              usb_version;
  } spcc_cfg_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } spcc_pins_t;

endpackage

//--- design/spcc_oneshot.sv
`timescale 1ns/1ps
module spcc_oneshot (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);

  logic [spcc_pkg::OS_W-1:0] cnt_r;

  // Retriggered on each activity cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (trigger) begin
      cnt_r <= spcc_pkg::OS_LOAD;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign active = trigger || (cnt_r != '0);

endmodule // spcc_oneshot

//--- design/spcc_nvstore.sv
`timescale 1ns/1ps
module spcc_nvstore (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_en,
  input  wire logic [spcc_pkg::NV_AW-1:0] wr_addr,
  input  wire logic [15:0]              wr_data,
  input  wire logic [spcc_pkg::NV_AW-1:0] rd_addr,
  output logic [15:0]                   rd_data
);

  logic [15:0] mem_r [spcc_pkg::NV_WORDS];

  // Reset stands in for factory programming
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < spcc_pkg::NV_WORDS; i++) begin
        mem_r[i] <= spcc_pkg::NV_DEF_BLANK;
      end
      mem_r[spcc_pkg::NV_ADDR_PIN01]   <= spcc_pkg::NV_DEF_PIN01;
      mem_r[spcc_pkg::NV_ADDR_PIN234]  <= spcc_pkg::NV_DEF_PIN234;
      mem_r[spcc_pkg::NV_ADDR_OPTIONS] <= spcc_pkg::NV_DEF_OPTIONS;
      mem_r[spcc_pkg::NV_ADDR_USB]     <= spcc_pkg::NV_DEF_USB;
    end else if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // spcc_nvstore

//--- design/spcc_top.sv
// Summary of operation
// - After power-on or USB bus reset the block scans its store and loads descriptors and pin options.
// - A power-enable pin drives low after enumeration and high while the link is suspended.
// - A suspend-indicator pin drives low for as long as the link is suspended.
// - During serial transmit or receive the matching activity pin goes from released to driving low.
// - Activity indication is stretched by a one-shot timer so brief transfers stay visible.
// - Each pin offers transmit, receive and combined activity LED choices.
// - With pull-down-on-suspend enabled, UART lines are pulled low while power-enable is high; off by default.
// - With remote wake enabled, ring-indicate low during suspend makes the block signal resume to the host.
// - Each of the eight UART lines has its own polarity inversion option, all off by default.
// - Default functions are receive LED, transmit LED, power-enable twice and suspend indicator.
// - The configured USB version is reported, 2.0 by default, and the link runs only at full speed.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module spcc_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        usb_reset,
  input  wire logic        usb_configured,
  input  wire logic        usb_suspended,
  input  wire logic        nv_wr_en,
  input  wire logic [2:0]  nv_wr_addr,
  input  wire logic [15:0] nv_wr_data,
  input  wire logic        tx_active,
  input  wire logic        rx_active,
  input  wire logic        core_txd,
  output logic             core_rxd,
  input  wire logic        core_rts_n,
  output logic             core_cts_n,
  input  wire logic        core_dtr_n,
  output logic             core_dsr_n,
  output logic             core_dcd_n,
  output logic             core_ri_n,
  input  wire logic [7:0]  uart_in,
  output logic [7:0]       uart_out,
  output logic [7:0]       uart_oe,
  output logic [4:0]       config_pin_out,
  output logic [4:0]       config_pin_oe,
  output logic             resume_req,
  output logic             cfg_valid,
  output logic [15:0]      usb_version,
  output logic             full_speed_only
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_DONE = 2'b11
  } spcc_state_t;

  logic                      rst_s1_r;
  logic                      rst_n_r;
  spcc_state_t               state_r;
  logic [2:0]                addr_r;
  logic [2:0]                addr_q_r;
  logic                      data_vld_r;
  logic [15:0]               nv_rd_data;
  spcc_pkg::spcc_cfg_t       cfg_r;
  spcc_pkg::spcc_pins_t      pins_nxt;
  logic                      tx_led_on;
  logic                      rx_led_on;
  logic                      susp_q_r;
  logic [spcc_pkg::OS_W-1:0] resume_cnt_r;
  logic [7:0]                uart_core_out;
  logic [7:0]                uart_dir_out;
  logic [7:0]                uart_in_eff;
  logic                      pwr_high;

  function automatic logic is_led(input logic [3:0] fn);
    is_led = (fn == spcc_pkg::FN_TX_LED) || (fn == spcc_pkg::FN_RX_LED) || (fn == spcc_pkg::FN_ANY_LED);
  endfunction

  // Reset release through two stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  spcc_nvstore u_nv (
    .clk     (clk),
    .rst_n   (rst_n_r),
    .wr_en   (nv_wr_en && (state_r == ST_DONE)),
    .wr_addr (nv_wr_addr),
    .wr_data (nv_wr_data),
    .rd_addr (addr_r),
    .rd_data (nv_rd_data)
  );

  // Scan sequencer, rerun on every USB reset
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r    <= ST_IDLE;
      addr_r     <= '0;
      addr_q_r   <= '0;
      data_vld_r <= 1'b0;
    end else if (usb_reset) begin
      state_r    <= ST_IDLE;
      addr_r     <= '0;
      data_vld_r <= 1'b0;
    end else begin
      addr_q_r <= addr_r;
      case (state_r)
        ST_IDLE: begin
          state_r    <= ST_READ;
          addr_r     <= '0;
          data_vld_r <= 1'b0;
        end
        ST_READ: begin
          data_vld_r <= 1'b1;
          if (addr_r == spcc_pkg::NV_ADDR_LAST) begin
            state_r <= ST_DONE;
          end else begin
            addr_r <= addr_r + 3'h1;
          end
        end
        ST_DONE: begin
          data_vld_r <= 1'b0;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Loaded image; each field keeps its value until the scan reads its word
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r.pin_fn      <= {spcc_pkg::FN_SUSPEND, spcc_pkg::FN_PWR_EN, spcc_pkg::FN_PWR_EN,
                            spcc_pkg::FN_TX_LED, spcc_pkg::FN_RX_LED};
      cfg_r.invert      <= '0;
      cfg_r.pulldown_en <= 1'b0;
      cfg_r.wake_en     <= 1'b1;
      cfg_r.usb_version <= spcc_pkg::USB_VER_20;
    end else if (data_vld_r) begin
      case (addr_q_r)
        spcc_pkg::NV_ADDR_PIN01: begin
          cfg_r.pin_fn[0] <= nv_rd_data[3:0];
          cfg_r.pin_fn[1] <= nv_rd_data[7:4];
        end
        spcc_pkg::NV_ADDR_PIN234: begin
          cfg_r.pin_fn[2] <= nv_rd_data[3:0];
          cfg_r.pin_fn[3] <= nv_rd_data[7:4];
          cfg_r.pin_fn[4] <= nv_rd_data[11:8];
        end
        spcc_pkg::NV_ADDR_OPTIONS: begin
          cfg_r.invert      <= nv_rd_data[spcc_pkg::OPT_INV_LSB +: spcc_pkg::NUM_UART];
          cfg_r.pulldown_en <= nv_rd_data[spcc_pkg::OPT_PULLDN_BIT];
          cfg_r.wake_en     <= nv_rd_data[spcc_pkg::OPT_WAKE_BIT];
        end
        spcc_pkg::NV_ADDR_USB: begin
          cfg_r.usb_version <= nv_rd_data;
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  spcc_oneshot u_tx_os (
    .clk     (clk),
    .rst_n   (rst_n_r),
    .trigger (tx_active),
    .active  (tx_led_on)
  );

  spcc_oneshot u_rx_os (
    .clk     (clk),
    .rst_n   (rst_n_r),
    .trigger (rx_active),
    .active  (rx_led_on)
  );

  // Power stays off until enumeration completes
  assign pwr_high = usb_suspended || !usb_configured;

  // Per-pin function decode
  always_comb begin
    pins_nxt = '0;
    for (int p = 0; p < spcc_pkg::NUM_PINS; p++) begin
      case (cfg_r.pin_fn[p])
        spcc_pkg::FN_TX_LED: begin
          pins_nxt.oe[p] = tx_led_on;
        end
        spcc_pkg::FN_RX_LED: begin
          pins_nxt.oe[p] = rx_led_on;
        end
        spcc_pkg::FN_ANY_LED: begin
          pins_nxt.oe[p] = tx_led_on || rx_led_on;
        end
        spcc_pkg::FN_PWR_EN: begin
          pins_nxt.oe[p]  = 1'b1;
          pins_nxt.out[p] = pwr_high;
        end
        spcc_pkg::FN_SUSPEND: begin
          pins_nxt.oe[p]  = 1'b1;
          pins_nxt.out[p] = !usb_suspended;
        end
        default: begin
          pins_nxt.oe[p] = 1'b0;
        end
      endcase
      if (is_led(cfg_r.pin_fn[p])) begin
        pins_nxt.out[p] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      config_pin_out <= '0;
      config_pin_oe  <= '0;
    end else begin
      config_pin_out <= pins_nxt.out;
      config_pin_oe  <= pins_nxt.oe;
    end
  end

  // Line directions: TXD, RTS, DTR are driven by the block
  assign uart_core_out = {1'b0, 1'b0, 1'b0, core_dtr_n, 1'b0, core_rts_n, 1'b0, core_txd};
  assign uart_dir_out  = 8'b0001_0101;
  assign uart_in_eff   = uart_in ^ cfg_r.invert;

  // Pad outputs; pull-down overrides when power is off
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      uart_out <= 8'h15;
      uart_oe  <= 8'h15;
    end else if (cfg_r.pulldown_en && pwr_high) begin
      uart_out <= '0;
      uart_oe  <= 8'hFF;
    end else begin
      uart_out <= (uart_core_out ^ cfg_r.invert) & uart_dir_out;
      uart_oe  <= uart_dir_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      core_rxd   <= 1'b1;
      core_cts_n <= 1'b1;
      core_dsr_n <= 1'b1;
      core_dcd_n <= 1'b1;
      core_ri_n  <= 1'b1;
    end else begin
      core_rxd   <= uart_in_eff[spcc_pkg::UL_RXD];
      core_cts_n <= uart_in_eff[spcc_pkg::UL_CTS];
      core_dsr_n <= uart_in_eff[spcc_pkg::UL_DSR];
      core_dcd_n <= uart_in_eff[spcc_pkg::UL_DCD];
      core_ri_n  <= uart_in_eff[spcc_pkg::UL_RI];
    end
  end

  // Resume pulse of fixed length, started when suspend, wake enable and ring-indicate low first coincide
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      susp_q_r     <= 1'b0;
      resume_cnt_r <= '0;
      resume_req   <= 1'b0;
    end else begin
      susp_q_r <= usb_suspended && cfg_r.wake_en && !uart_in_eff[spcc_pkg::UL_RI];
      if (!susp_q_r && usb_suspended && cfg_r.wake_en && !uart_in_eff[spcc_pkg::UL_RI]) begin
        resume_cnt_r <= spcc_pkg::RS_LOAD;
      end else if (resume_cnt_r != '0) begin
        resume_cnt_r <= resume_cnt_r - 1'b1;
      end
      resume_req <= (resume_cnt_r != '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_valid       <= 1'b0;
      usb_version     <= spcc_pkg::USB_VER_20;
      full_speed_only <= 1'b1;
    end else begin
      cfg_valid       <= (state_r == ST_DONE);
      usb_version     <= cfg_r.usb_version;
      full_speed_only <= 1'b1;
    end
  end

endmodule // spcc_top

//--- verification/spcc_host_model.sv
`timescale 1ns/1ps
module spcc_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bus_reset,
  input  wire logic want_suspend,
  input  wire logic resume_req,
  output logic      usb_configured,
  output logic      usb_suspended
);
  logic [5:0] enum_cnt_r;
  logic       woken_r;

  // Slow enumeration so the unconfigured power state can be seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enum_cnt_r     <= 6'h00;
      usb_configured <= 1'b0;
    end else if (bus_reset) begin
      enum_cnt_r     <= 6'h00;
      usb_configured <= 1'b0;
    end else if (enum_cnt_r != 6'h3F) begin
      enum_cnt_r <= enum_cnt_r + 6'h01;
    end else begin
      usb_configured <= 1'b1;
    end
  end

  // Suspend ends as soon as resume signalling is heard
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      woken_r       <= 1'b0;
      usb_suspended <= 1'b0;
    end else begin
      woken_r       <= want_suspend && (woken_r || resume_req);
      usb_suspended <= want_suspend && !woken_r && !resume_req && usb_configured;
    end
  end
endmodule // spcc_host_model

//--- verification/spcc_asserts.sv
`timescale 1ns/1ps
module spcc_asserts (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       usb_reset,
  input wire logic       usb_configured,
  input wire logic       usb_suspended,
  input wire logic       tx_active,
  input wire logic       rx_active,
  input wire logic [7:0] uart_out,
  input wire logic [7:0] uart_oe,
  input wire logic [4:0] config_pin_out,
  input wire logic [4:0] config_pin_oe,
  input wire logic       resume_req,
  input wire logic       cfg_valid,
  input wire logic       full_speed_only
);
  localparam int OS_N = spcc_pkg::ONESHOT_CYCLES;
  localparam int RS_N = spcc_pkg::RESUME_CYCLES;
  logic [10:0] idle_cnt_r;
  logic [7:0]  rs_cnt_r;

  // Saturates so a long idle spell never wraps into the stretch window
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) idle_cnt_r <= 11'h7FF;
    else if (tx_active || rx_active) idle_cnt_r <= 11'h000;
    else if (idle_cnt_r != 11'h7FF) idle_cnt_r <= idle_cnt_r + 11'h001;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rs_cnt_r <= 8'h00;
    else rs_cnt_r <= resume_req ? rs_cnt_r + 8'h01 : 8'h00;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_resume_start; $rose(resume_req); endsequence
  sequence s_led_drop; $fell(config_pin_oe[0]) || $fell(config_pin_oe[1]); endsequence
  sequence s_settled; cfg_valid && $past(cfg_valid) && $stable(usb_suspended) && $stable(usb_configured); endsequence

  property p_full_speed; cfg_valid |-> full_speed_only; endproperty
  a_full_speed: assert property (p_full_speed) else $error("full speed flag low");
  property p_scan_done; $fell(usb_reset) |-> ##[1:20] cfg_valid; endproperty
  a_scan_done: assert property (p_scan_done) else $error("scan did not finish");
  property p_led_low; 1'b1 |-> (config_pin_out[1:0] & config_pin_oe[1:0]) == 2'b00; endproperty
  a_led_low: assert property (p_led_low) else $error("activity pin driven high");
  property p_led_cause; $rose(config_pin_oe[0]) || $rose(config_pin_oe[1]) |-> $past(tx_active || rx_active); endproperty
  a_led_cause: assert property (p_led_cause) else $error("activity pin on without traffic");
  property p_led_stretch; s_led_drop |-> idle_cnt_r >= OS_N - 5 && idle_cnt_r <= OS_N + 5; endproperty
  a_led_stretch: assert property (p_led_stretch) else $error("stretch length wrong");
  property p_led_release; idle_cnt_r > OS_N + 5 |-> config_pin_oe[1:0] == 2'b00; endproperty
  a_led_release: assert property (p_led_release) else $error("activity pin not released");
  property p_pwr_pin; s_settled |-> config_pin_out[3:2] == {2{usb_suspended || !usb_configured}}; endproperty
  a_pwr_pin: assert property (p_pwr_pin) else $error("power pin level wrong");
  property p_susp_pin; s_settled |-> config_pin_out[4] == !usb_suspended && config_pin_oe[4]; endproperty
  a_susp_pin: assert property (p_susp_pin) else $error("suspend pin level wrong");
  property p_pulldown; uart_oe == 8'hFF |-> uart_out == 8'h00 && (config_pin_out[2] || $past(config_pin_out[2])); endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down outside power-off");
  property p_resume_cause; s_resume_start |-> $past(usb_suspended, 2); endproperty
  a_resume_cause: assert property (p_resume_cause) else $error("resume while awake");
  property p_resume_len; $fell(resume_req) |-> rs_cnt_r == RS_N; endproperty
  a_resume_len: assert property (p_resume_len) else $error("resume length wrong");
endmodule // spcc_asserts

//--- verification/spcc_tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        usb_reset = 1'b0;
  logic        want_susp = 1'b0;
  logic        nv_wr_en = 1'b0;
  logic [2:0]  nv_wr_addr = 3'h0;
  logic [15:0] nv_wr_data = 16'h0000;
  logic        tx_active = 1'b0;
  logic        rx_active = 1'b0;
  logic        core_txd = 1'b1;
  logic        core_rts_n = 1'b1;
  logic        core_dtr_n = 1'b1;
  logic [7:0]  uart_in = 8'hFF;
  logic        usb_configured, usb_suspended, core_rxd, core_cts_n, core_dsr_n, core_dcd_n, core_ri_n;
  logic        resume_req, cfg_valid, full_speed_only;
  logic [7:0]  uart_out, uart_oe, inv;
  logic [4:0]  config_pin_out, config_pin_oe;
  logic [15:0] usb_version;
  logic [15:0] led_tbl [3] = '{16'h0001, 16'h0010, 16'h0022};
  integer      seed = 80;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          i, len;

  always #50 clk = ~clk;

  spcc_top dut_u (.clk(clk), .reset_n(reset_n), .usb_reset(usb_reset), .usb_configured(usb_configured),
    .usb_suspended(usb_suspended), .nv_wr_en(nv_wr_en), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data),
    .tx_active(tx_active), .rx_active(rx_active), .core_txd(core_txd), .core_rxd(core_rxd),
    .core_rts_n(core_rts_n), .core_cts_n(core_cts_n), .core_dtr_n(core_dtr_n), .core_dsr_n(core_dsr_n),
    .core_dcd_n(core_dcd_n), .core_ri_n(core_ri_n), .uart_in(uart_in), .uart_out(uart_out), .uart_oe(uart_oe),
    .config_pin_out(config_pin_out), .config_pin_oe(config_pin_oe), .resume_req(resume_req),
    .cfg_valid(cfg_valid), .usb_version(usb_version), .full_speed_only(full_speed_only));

  spcc_host_model host_u (.clk(clk), .rst_n(reset_n), .bus_reset(usb_reset), .want_suspend(want_susp),
    .resume_req(resume_req), .usb_configured(usb_configured), .usb_suspended(usb_suspended));

  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic led_on(input logic [3:0] fn, input logic t, input logic r);
    return (fn == spcc_pkg::FN_TX_LED && t) || (fn == spcc_pkg::FN_RX_LED && r) ||
           (fn == spcc_pkg::FN_ANY_LED && (t || r));
  endfunction

  // New store contents only take hold after a bus reset rescans them
  task automatic nv_load(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    nv_wr_en <= 1'b1;
    nv_wr_addr <= a;
    nv_wr_data <= d;
    @(posedge clk);
    nv_wr_en <= 1'b0;
    usb_reset <= 1'b1;
    repeat (2) @(posedge clk);
    usb_reset <= 1'b0;
    for (i = 0; i < 200 && usb_configured !== 1'b1; i++) @(negedge clk);
    chk(cfg_valid, 1'b1);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (i = 0; i < 40 && cfg_valid !== 1'b1; i++) @(negedge clk);
    look(2);
    chk({usb_version, full_speed_only}, {16'h0200, 1'b1});
    chk(config_pin_out[3:2], 2'h3);
    for (i = 0; i < 100 && usb_configured !== 1'b1; i++) @(negedge clk);
    look(3);
    chk({config_pin_oe, config_pin_out[4:2]}, 8'hE4);
    foreach (led_tbl[k]) begin
      nv_load(spcc_pkg::NV_ADDR_PIN01, led_tbl[k]);
      for (int s = 0; s < 2; s++) begin
        len = 1 + ($unsigned($random(seed)) % 3);
        @(posedge clk);
        tx_active <= (s == 0);
        rx_active <= (s == 1);
        repeat (len) @(posedge clk);
        tx_active <= 1'b0;
        rx_active <= 1'b0;
        @(negedge clk);
        chk({config_pin_oe[1:0], config_pin_out[1:0] & config_pin_oe[1:0]}, {led_on(led_tbl[k][7:4], s == 0, s == 1),
            led_on(led_tbl[k][3:0], s == 0, s == 1), 2'b00});
        look(spcc_pkg::ONESHOT_CYCLES - 100);
        chk(config_pin_oe[1:0], {led_on(led_tbl[k][7:4], s == 0, s == 1), led_on(led_tbl[k][3:0], s == 0, s == 1)});
        look(120);
        chk(config_pin_oe[1:0], 2'b00);
      end
    end
    repeat (4) begin
      inv = 8'($random(seed));
      nv_load(spcc_pkg::NV_ADDR_OPTIONS, {8'h02, inv});
      repeat (4) begin
        @(posedge clk);
        uart_in <= 8'($random(seed));
        {core_txd, core_rts_n, core_dtr_n} <= 3'($random(seed));
        look(2);
        chk({core_rxd, core_cts_n, core_dsr_n, core_dcd_n, core_ri_n}, {uart_in[1] ^ inv[1], uart_in[3] ^ inv[3],
            uart_in[5] ^ inv[5], uart_in[6] ^ inv[6], uart_in[7] ^ inv[7]});
        chk({uart_oe, uart_out[4], uart_out[2], uart_out[0]}, {8'h15, core_dtr_n ^ inv[4], core_rts_n ^ inv[2],
            core_txd ^ inv[0]});
      end
    end
    @(posedge clk);
    uart_in <= 8'hFF;
    nv_load(spcc_pkg::NV_ADDR_OPTIONS, 16'h0300);
    @(posedge clk);
    want_susp <= 1'b1;
    look(4);
    chk({config_pin_out[4:2], uart_oe, uart_out}, {3'h3, 8'hFF, 8'h00});
    @(posedge clk);
    uart_in <= 8'h7F;
    for (i = 0; i < 10 && resume_req !== 1'b1; i++) @(negedge clk);
    chk(resume_req, 1'b1);
    look(spcc_pkg::RESUME_CYCLES - 6);
    chk(resume_req, 1'b1);
    look(10);
    chk(resume_req, 1'b0);
    @(posedge clk);
    want_susp <= 1'b0;
    uart_in <= 8'hFF;
    look(4);
    chk({config_pin_out[4:2], uart_oe}, {3'h4, 8'h15});
    nv_load(spcc_pkg::NV_ADDR_USB, 16'h0200);
    look(2);
    chk(usb_version, 16'h0200);
    nv_load(spcc_pkg::NV_ADDR_OPTIONS, 16'h0000);
    @(posedge clk);
    want_susp <= 1'b1;
    look(4);
    chk(uart_oe, 8'h15);
    @(posedge clk);
    uart_in <= 8'h7F;
    look(20);
    chk(resume_req, 1'b0);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule // tb

bind spcc_top spcc_asserts chk_u (.clk(clk), .reset_n(reset_n), .usb_reset(usb_reset),
  .usb_configured(usb_configured), .usb_suspended(usb_suspended), .tx_active(tx_active), .rx_active(rx_active),
  .uart_out(uart_out), .uart_oe(uart_oe), .config_pin_out(config_pin_out), .config_pin_oe(config_pin_oe),
  .resume_req(resume_req), .cfg_valid(cfg_valid), .full_speed_only(full_speed_only));
